// ### hw/gpp_port.v
`include "gpp_defs.vh"
module gpp_port #(
  parameter NPINS = 8,
  parameter [7:0] PERIPH_PRESENT = 8'hff
) (
  clk,
  nrst,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  pin_in,
  pin_out,
  pin_oe,
  pull_up_en,
  pull_dn_en,
  drive_sel,
  slew_en,
  periph_out,
  periph_oe,
  periph_in,
  irq
);
  input wire clk;
  input wire nrst;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output reg pslverr;
  input wire [7:0] pin_in;
  output reg [7:0] pin_out;
  output reg [7:0] pin_oe;
  output reg [7:0] pull_up_en;
  output reg [7:0] pull_dn_en;
  output reg [15:0] drive_sel;
  output reg [7:0] slew_en;
  input wire [7:0] periph_out;
  input wire [7:0] periph_oe;
  output reg [7:0] periph_in;
  output reg irq;

  // ==========================================================
  // state
  reg [7:0] dout_q, dir_q, hw_q, paden_q, od_q, pu_q, pd_q;
  reg [7:0] slew_q, imask_q, icl_q;
  reg [15:0] drv_q;
  reg [23:0] trig_q;
  reg [2:0] qidx_m_q;
  reg [2:0] qidx_t_q;
  wire [7:0] present;
  wire [7:0] ris;
  wire [7:0] pad_in;
  wire [7:0] arm;
  wire wr_stb, rd_stb;
  wire is_data;
  wire [7:0] sel_mask;
  reg [31:0] rd_d;
  reg err_d;
  integer i;
  integer j;

  // ==========================================================
  // functions
  function [1:0] mode_code;
    input d;
    input h;
    begin
      if (h)
        mode_code = `GPP_MODE_HW;
      else if (d)
        mode_code = `GPP_MODE_OUT;
      else
        mode_code = `GPP_MODE_IN;
    end
  endfunction

  function [7:0] merge;
    input [7:0] old;
    input [7:0] val;
    input [7:0] m;
    begin
      merge = (old & ~m) | (val & m);
    end
  endfunction

  // ==========================================================
  // bus handshake
  gpp_apb u_apb (
    .clk(clk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb)
  );

  assign present = (NPINS >= 8) ? 8'hff :
    ((8'h01 << NPINS) - 8'h01);
  assign is_data = (paddr < `GPP_DIR);
  assign sel_mask = paddr[9:2] & present;
  // unpadded pins read as zero, keeping stale levels out
  assign pad_in = pin_in & paden_q & present;
  // only padded sw inputs are armed: a low-level trigger fed a
  // forced zero on an unpadded pin would latch forever
  assign arm = paden_q & ~dir_q & ~hw_q & present;

  // ==========================================================
  // trigger units
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_trig
      gpp_trig u_trig (
        .clk(clk),
        .nrst(nrst),
        .pin_in(pad_in[g]),
        .trig_code(arm[g] ? trig_q[3*g +: 3] : 3'h7),
        .clr(icl_q[g]),
        .latched(ris[g])
      );
    end
  endgenerate

  // ==========================================================
  // register writes
  always @(posedge clk) begin
    if (!nrst) begin
      dout_q <= `GPP_RST_BYTE;
      dir_q <= `GPP_RST_BYTE;
      hw_q <= `GPP_RST_BYTE;
      paden_q <= `GPP_RST_BYTE;
      od_q <= `GPP_RST_BYTE;
      pu_q <= `GPP_RST_BYTE;
      pd_q <= `GPP_RST_BYTE;
      slew_q <= `GPP_RST_BYTE;
      drv_q <= `GPP_RST_DRV;
      trig_q <= `GPP_RST_TRIG;
      imask_q <= `GPP_RST_BYTE;
      icl_q <= `GPP_RST_BYTE;
      qidx_m_q <= 3'h0;
      qidx_t_q <= 3'h0;
    end else begin
      icl_q <= 8'h00;
      if (wr_stb && pwrite) begin
        if (is_data)
          dout_q <= merge(dout_q, pwdata[7:0], sel_mask);
        else if (paddr == `GPP_DIR)
          dir_q <= pwdata[7:0] & present;
        else if (paddr == `GPP_HWSEL)
          hw_q <= pwdata[7:0] & present;
        else if (paddr == `GPP_TRIG_BASE) begin
          // begin/end keeps the next else on the decode chain
          for (i = 0; i < 8; i = i + 1)
            if (pwdata[8+i] && pwdata[2:0] <= `GPP_TRIG_HIGH)
              trig_q[3*i +: 3] <= pwdata[2:0];
        end else if (paddr == `GPP_PADEN)
          paden_q <= pwdata[7:0] & present;
        else if (paddr == `GPP_ODEN)
          od_q <= pwdata[7:0] & present;
        else if (paddr == `GPP_PULLUP) begin
          pu_q <= pwdata[7:0] & present;
          pd_q <= pd_q & ~pwdata[7:0];
        end else if (paddr == `GPP_PULLDN) begin
          pd_q <= pwdata[7:0] & present;
          pu_q <= pu_q & ~pwdata[7:0];
        end else if (paddr == `GPP_DRIVE) begin
          // code in bits 1:0, pin mask in bits 15:8; code 3 refused
          for (i = 0; i < 8; i = i + 1)
            if (pwdata[8+i] && pwdata[1:0] != 2'h3)
              drv_q[2*i +: 2] <= pwdata[1:0];
        end else if (paddr == `GPP_SLEW)
          slew_q <= pwdata[7:0] & present;
        else if (paddr == `GPP_IMASK)
          imask_q <= pwdata[7:0] & present;
        else if (paddr == `GPP_ICLR)
          icl_q <= pwdata[7:0];
        else if (paddr == `GPP_MODE_QUERY)
          qidx_m_q <= pwdata[2:0];
        else if (paddr == `GPP_TRIG_QUERY)
          qidx_t_q <= pwdata[2:0];
      end
    end
  end

  // ==========================================================
  // read mux
  always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    if (is_data)
      rd_d = {24'h000000, pad_in & sel_mask};
    else if (paddr == `GPP_DIR)
      rd_d = {24'h000000, dir_q};
    else if (paddr == `GPP_HWSEL)
      rd_d = {24'h000000, hw_q};
    else if (paddr == `GPP_PADEN)
      rd_d = {24'h000000, paden_q};
    else if (paddr == `GPP_ODEN)
      rd_d = {24'h000000, od_q};
    else if (paddr == `GPP_PULLUP)
      rd_d = {24'h000000, pu_q};
    else if (paddr == `GPP_PULLDN)
      rd_d = {24'h000000, pd_q};
    else if (paddr == `GPP_DRIVE)
      rd_d = {16'h0000, drv_q};
    else if (paddr == `GPP_SLEW)
      rd_d = {24'h000000, slew_q};
    else if (paddr == `GPP_IMASK)
      rd_d = {24'h000000, imask_q};
    else if (paddr == `GPP_RIS)
      rd_d = {24'h000000, ris};
    else if (paddr == `GPP_MIS)
      rd_d = {24'h000000, ris & imask_q};
    else if (paddr == `GPP_ICLR || paddr == `GPP_TRIG_BASE)
      rd_d = 32'h00000000;
    else if (paddr == `GPP_MODE_QUERY)
      rd_d = {27'h0000000, qidx_m_q,
        mode_code(dir_q[qidx_m_q], hw_q[qidx_m_q])};
    else if (paddr == `GPP_TRIG_QUERY)
      rd_d = {26'h0000000, qidx_t_q,
        trig_q[3*qidx_t_q +: 3]};
    else
      err_d = 1'b1;
  end

  always @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (rd_stb) begin
      prdata <= pwrite ? 32'h00000000 : rd_d;
      pslverr <= err_d;
    end
  end

  // ==========================================================
  // pad side: everything registered so pins never glitch
  always @(posedge clk) begin
    if (!nrst) begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pull_up_en <= 8'h00;
      pull_dn_en <= 8'h00;
      drive_sel <= `GPP_RST_DRV;
      slew_en <= 8'h00;
      periph_in <= 8'h00;
      irq <= 1'b0;
    end else begin
      for (j = 0; j < 8; j = j + 1) begin
        if (hw_q[j] && !PERIPH_PRESENT[j]) begin
          pin_out[j] <= 1'b0;
          pin_oe[j] <= 1'b0;
        end else if (hw_q[j]) begin
          pin_out[j] <= periph_out[j] & ~od_q[j];
          pin_oe[j] <= paden_q[j] & periph_oe[j] &
            (~od_q[j] | ~periph_out[j]);
        end else begin
          // open drain only ever drives low
          pin_out[j] <= dout_q[j] & ~od_q[j];
          pin_oe[j] <= paden_q[j] & dir_q[j] &
            (~od_q[j] | ~dout_q[j]);
        end
        slew_en[j] <= slew_q[j] &
          (drv_q[2*j +: 2] == `GPP_DRV_8MA);
      end
      pull_up_en <= pu_q & paden_q;
      pull_dn_en <= pd_q & paden_q;
      drive_sel <= drv_q;
      periph_in <= pad_in & hw_q & PERIPH_PRESENT;
      irq <= |(ris & imask_q);
    end
  end
endmodule // gpp_port

// ### hw/gpp_defs.vh
`ifndef GPP_DEFS_VH
`define GPP_DEFS_VH
// ==========================================================
// register byte offsets (data window spans 0x000..0x3fc)
`define GPP_DATA_BASE 12'h000
`define GPP_DIR 12'h400
`define GPP_HWSEL 12'h404
`define GPP_TRIG_BASE 12'h408
`define GPP_PADEN 12'h40c
`define GPP_ODEN 12'h410
`define GPP_PULLUP 12'h414
`define GPP_PULLDN 12'h418
`define GPP_DRIVE 12'h41c
`define GPP_SLEW 12'h420
`define GPP_IMASK 12'h424
`define GPP_RIS 12'h428
`define GPP_MIS 12'h42c
`define GPP_ICLR 12'h430
`define GPP_MODE_QUERY 12'h434
`define GPP_TRIG_QUERY 12'h438
// ==========================================================
// mode codes
`define GPP_MODE_IN 2'h0
`define GPP_MODE_OUT 2'h1
`define GPP_MODE_HW 2'h2
// trigger codes
`define GPP_TRIG_FALL 3'h0
`define GPP_TRIG_RISE 3'h1
`define GPP_TRIG_BOTH 3'h2
`define GPP_TRIG_LOW 3'h3
`define GPP_TRIG_HIGH 3'h4
// drive codes
`define GPP_DRV_2MA 2'h0
`define GPP_DRV_4MA 2'h1
`define GPP_DRV_8MA 2'h2
// ==========================================================
// field positions and reset values
`define GPP_MASK_LSB 2
`define GPP_IDX_LSB 0
`define GPP_RST_BYTE 8'h00
`define GPP_RST_DRV 16'h0000
`define GPP_RST_TRIG 24'h000000
`endif

// ### hw/gpp_trig.v
`include "gpp_defs.vh"
module gpp_trig (
  clk,
  nrst,
  pin_in,
  trig_code,
  clr,
  latched
);
  input wire clk;
  input wire nrst;
  input wire pin_in;
  input wire [2:0] trig_code;
  input wire clr;
  output reg latched;
  reg prev_q;
  reg hit;
  // ==========================================================
  // event detect
  always @* begin
    case (trig_code)
      `GPP_TRIG_FALL: hit = prev_q & ~pin_in;
      `GPP_TRIG_RISE: hit = ~prev_q & pin_in;
      `GPP_TRIG_BOTH: hit = prev_q ^ pin_in;
      `GPP_TRIG_LOW: hit = ~pin_in;
      `GPP_TRIG_HIGH: hit = pin_in;
      default: hit = 1'b0;
    endcase
  end
  // set wins over a clear in the same cycle
  always @(posedge clk) begin
    if (!nrst) begin
      prev_q <= 1'b0;
      latched <= 1'b0;
    end else begin
      prev_q <= pin_in;
      latched <= hit | (latched & ~clr);
    end
  end
endmodule // gpp_trig

// ### hw/gpp_apb.v
`include "gpp_defs.vh"
module gpp_apb (
  clk,
  nrst,
  psel,
  penable,
  pready,
  wr_stb,
  rd_stb
);
  input wire clk;
  input wire nrst;
  input wire psel;
  input wire penable;
  output reg pready;
  output wire wr_stb;
  output wire rd_stb;
  // one wait state: pready rises in the second access cycle
  always @(posedge clk) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end
  assign wr_stb = psel & penable & pready;
  assign rd_stb = psel & penable & ~pready;
endmodule // gpp_apb

// ### sim/gpp_port_sva.sv
// ==========================================================
// port checker
module gpp_port_sva (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] pin_oe,
  input wire [7:0] pull_up_en,
  input wire [7:0] pull_dn_en,
  input wire [15:0] drive_sel,
  input wire [7:0] slew_en,
  input wire irq
);
  logic [7:0] slew_bad;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      slew_bad[i] = slew_en[i] && (drive_sel[2*i+:2] != 2'h2);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  AST_PRDY_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("ready not after one wait");
  AST_PRDY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_PRDY_QUAL: assert property (pready |-> s_access)
    else $error("ready outside access");
  AST_RST_DEF: assert property ($rose(nrst) |-> pin_oe == 8'h00
    && {pull_up_en, pull_dn_en, slew_en} == 24'h0 && drive_sel == 16'h0 && !irq)
    else $error("outputs not at defaults after reset");
  AST_SLEW: assert property (slew_bad == 8'h00)
    else $error("slew without 8mA drive");
  AST_PULL: assert property ((pull_up_en & pull_dn_en) == 8'h00)
    else $error("pull up and down together");
  AST_UNMAP: assert property (s_access and (pready && paddr > 12'h438) |-> pslverr)
    else $error("unmapped access not refused");
  AST_RDMASK: assert property (s_access and (pready && !pwrite && paddr < 12'h400)
    |-> (prdata & ~{24'h0, paddr[9:2]}) == 32'h0)
    else $error("unselected data bits not zero");
endmodule // gpp_port_sva

// ### sim/gpp_pads.sv
// ==========================================================
// pad and board model
module gpp_pads (
  input wire clk,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] pull_up_en,
  input wire [7:0] pull_dn_en,
  input wire [7:0] ext_val,
  input wire [7:0] ext_en,
  output logic [7:0] pin_in
);
  logic [7:0] churn = 8'h5a;
  // floating pads wander so a stale level never passes for data
  always @(posedge clk) churn <= ~churn;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pull_up_en[i]) pin_in[i] = 1'b1;
      else if (pull_dn_en[i]) pin_in[i] = 1'b0;
      else pin_in[i] = churn[i];
    end
  end
endmodule // gpp_pads

// ### sim/test_gpio_port_pin_control.sv
`include "gpp_defs.vh"
module test_gpio_port_pin_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [7:0] periph_out, periph_oe, ext_val, ext_en, d1, d2, m, o, r;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [7:0] pin_in, pin_out, pin_oe, pull_up_en, pull_dn_en, slew_en;
  wire [7:0] periph_in;
  wire [15:0] drive_sel;
  int err_total, check_count, cyc;
  integer seed;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  gpp_port dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pull_up_en,
    .pull_dn_en, .drive_sel, .slew_en, .periph_out, .periph_oe, .periph_in,
    .irq);
  gpp_pads pads (.clk, .pin_out, .pin_oe, .pull_up_en, .pull_dn_en,
    .ext_val, .ext_en, .pin_in);
  // ==========================================================
  // tasks
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      err_total++;
      $display("ERROR %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic final_report;
    if (exp_q.size() != 0) err_total++;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // request held until ready, then one idle edge so no double drive
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    exp_q.push_back({2'b10, x});
    bus(1'b0, a, 32'h0);
  endtask
  // ==========================================================
  // clock, monitor, timeout
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
      if (e[33]) chk("prdata", prdata, e[31:0]);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      final_report();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    seed = 32'ha38f08fc;
    {nrst, psel, penable, pwrite, paddr, pwdata} = 48'h0;
    {periph_out, periph_oe, ext_val} = 24'h0;
    ext_en = 8'hff;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int a = 12'h400; a <= 12'h438; a += 4) begin
      if (a != 12'h408 && a != 12'h430) rd(a[11:0], 32'h0);
    end
    wr(`GPP_DIR, 32'h0f);
    wr(`GPP_HWSEL, 32'h80);
    wr(`GPP_PADEN, 32'hff);
    for (int i = 0; i < 8; i++) begin
      wr(`GPP_MODE_QUERY, i);
      rd(`GPP_MODE_QUERY, {i[2:0], i < 4 ? `GPP_MODE_OUT :
        (i == 7 ? `GPP_MODE_HW : `GPP_MODE_IN)});
    end
    for (int c = 0; c < 6; c++) begin
      wr(`GPP_TRIG_BASE, {16'h0, 8'h1 << c, 8'h0} | c);
      wr(`GPP_TRIG_QUERY, c);
      rd(`GPP_TRIG_QUERY, {c[2:0], c < 5 ? c[2:0] : `GPP_TRIG_FALL});
    end
    d1 = $random(seed);
    d2 = $random(seed);
    m = $random(seed);
    o = (d1 & ~m) | (d2 & m);
    wr(12'h3fc, d1);
    wr({2'b00, m, 2'b00}, d2);
    @(negedge clk);
    chk("pin_out", pin_out & 8'h0f, o & 8'h0f);
    chk("pin_oe", pin_oe, 8'h0f);
    r = $random(seed);
    @(posedge clk);
    ext_val <= r;
    for (int k = 0; k < 4; k++) begin
      m = $random(seed);
      rd({2'b00, m, 2'b00}, {r[7:4], o[3:0]} & m);
    end
    periph_out <= 8'hc0;
    periph_oe <= 8'hc0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("hw_pin", {pin_oe[7:6], pin_out[7], periph_in[7]}, 4'hb);
    @(posedge clk);
    periph_oe <= 8'h00;
    wr(`GPP_PULLUP, 32'h10);
    wr(`GPP_PULLDN, 32'h20);
    wr(`GPP_DRIVE, 32'h0302);
    wr(`GPP_DRIVE, 32'hff03);
    wr(`GPP_SLEW, 32'hff);
    @(negedge clk);
    chk("pulls", {pull_up_en, pull_dn_en}, 16'h1020);
    chk("drive", {drive_sel, slew_en}, 24'h000a03);
    @(posedge clk);
    wr(`GPP_ODEN, 32'h01);
    @(negedge clk);
    chk("od_pin", {pin_out[0], pin_oe[0]}, {1'b0, ~o[0]});
    @(posedge clk);
    wr(`GPP_ODEN, 32'h00);
    ext_val <= 8'h00;
    wr(`GPP_TRIG_BASE, 32'h2001);
    wr(`GPP_ICLR, 32'hff);
    wr(`GPP_IMASK, 32'h20);
    rd(`GPP_RIS, 32'h0);
    ext_val <= 8'h20;
    repeat (4) @(posedge clk);
    rd(`GPP_RIS, 32'h20);
    rd(`GPP_MIS, 32'h20);
    @(negedge clk);
    chk("irq", irq, 1);
    @(posedge clk);
    wr(`GPP_IMASK, 32'h0);
    rd(`GPP_MIS, 32'h0);
    @(negedge clk);
    chk("irq", irq, 0);
    @(posedge clk);
    wr(`GPP_ICLR, 32'h20);
    rd(`GPP_RIS, 32'h0);
    wr(`GPP_PADEN, 32'h0);
    @(negedge clk);
    chk("pin_oe", pin_oe, 8'h00);
    @(posedge clk);
    rd(12'h3fc, 32'h0);
    wr(12'h500, 32'h0);
    exp_q.push_back(34'h100000000);
    bus(1'b0, 12'h500, 32'h0);
    rd(`GPP_DIR, 32'h0f);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(`GPP_DIR, 32'h0);
    final_report();
  end
endmodule // test_gpio_port_pin_control
bind gpp_port gpp_port_sva chk_i (.clk, .nrst, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .pin_oe, .pull_up_en, .pull_dn_en,
  .drive_sel, .slew_en, .irq);
